// ===== supply_supervisor_event_mask.sv
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_event_mask (
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_HS_TRIP,
  input wire logic I_LS_TRIP,
  input wire logic I_WAKE,
  output logic O_IRQ,
  output logic O_POR_REQ,
  output logic O_GPIO_HIZ,
  output logic O_CPU_HOLD,
  output logic O_MAIN_CLK_MASK,
  output logic O_SUB_CLK_REQ,
  output logic O_OSC_OVERSHOOT,
  output logic O_LS_MON_ON,
  output logic [2:0] O_MAIN_CLK_DIV,
  output logic [2:0] O_LP_MODE,
  output supply_pkg::sup_state_t O_SUP_STATE
);
  import supply_pkg::*;

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE_HOLD} pwr_state_t;

  logic [CTRL_W-1:0] ctrl;
  logic [IRQ_W-1:0] status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] set_bits;
  logic [IRQ_W-1:0] clr_bits;
  logic [2:0] lp_mode;
  pwr_state_t state;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] over_cnt;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic hs_trip;
  logic ls_trip;
  logic wake;
  sup_cfg_t hs_cfg;
  sup_cfg_t ls_cfg;
  logic deep;
  logic hs_on;
  logic ls_on;
  logic hs_evt;
  logic ls_evt;
  logic hs_settle;
  logic ls_settle;
  logic hs_settle_d;
  logic ls_settle_d;
  logic ls_normal;
  logic por;
  logic wake_done;
  logic [CNT_W-1:0] next_hold_cnt;

  // AHB-Lite slave
  logic addr_ok;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] dp_addr;
  logic [31:0] rd_mux;

  assign addr_ok = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
  // Reads take one wait state so a read right after a write sees the new value
  assign O_HREADYOUT = !rd_pend;
  assign O_HRESP = HRESP_OKAY;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      if (addr_ok) begin
        wr_pend <= I_HWRITE;
        rd_pend <= !I_HWRITE;
        dp_addr <= I_HADDR[7:0];
      end else begin
        wr_pend <= 1'b0;
        rd_pend <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (dp_addr)
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl;
      ADDR_STATUS: rd_mux[IRQ_W-1:0] = status;
      ADDR_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
      ADDR_MODE: rd_mux[2:0] = lp_mode;
      ADDR_STATE: rd_mux[6:0] = {O_OSC_OVERSHOOT, O_GPIO_HIZ, O_CPU_HOLD, hs_on, ls_on, hs_settle, ls_settle};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (rd_pend) begin
      O_HRDATA <= rd_mux;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      ctrl <= CTRL_RESET; // [R5]
      irq_mask <= '0;
    end else if (wr_pend) begin
      if (dp_addr == ADDR_CTRL) begin
        ctrl <= I_HWDATA[CTRL_W-1:0];
      end
      if (dp_addr == ADDR_MASK) begin
        irq_mask <= I_HWDATA[IRQ_W-1:0];
      end
    end
  end

  // Pins from the comparators and the wake source are asynchronous
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {I_WAKE, I_LS_TRIP, I_HS_TRIP};
      sync2 <= sync1;
    end
  end
  assign hs_trip = sync2[0];
  assign ls_trip = sync2[1];
  assign wake = sync2[2];

  assign hs_cfg = '{enable: ctrl[C_HS + C_EN], full_perf: ctrl[C_HS + C_FP],
                    reset_enable: ctrl[C_HS + C_RST], lowpower_keep: ctrl[C_HS + C_KEEP]};
  assign ls_cfg = '{enable: ctrl[C_LS + C_EN], full_perf: ctrl[C_LS + C_FP],
                    reset_enable: ctrl[C_LS + C_RST], lowpower_keep: ctrl[C_LS + C_KEEP]};
  assign deep = (state == ST_SLEEP) && (lp_mode >= MODE_DEEP_MIN);

  supervisor_channel u_high_side (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_cfg(hs_cfg),
    .i_deep(deep),
    .i_trip(hs_trip),
    .o_cmp_on(hs_on),
    .o_event(hs_evt),
    .o_settling(hs_settle)
  );

  supervisor_channel u_low_side (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_cfg(ls_cfg),
    .i_deep(deep),
    .i_trip(ls_trip),
    .o_cmp_on(ls_on),
    .o_event(ls_evt),
    .o_settling(ls_settle)
  );

  // The monitor follows the same keep rule as the low-side supervisor
  assign O_LS_MON_ON = ctrl[C_LMON_EN] && !(deep && !ctrl[C_LS + C_KEEP]); // [R4]
  assign O_SUP_STATE = '{hs_cmp_on: hs_on, ls_cmp_on: ls_on, hs_settling: hs_settle, ls_settling: ls_settle};

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      hs_settle_d <= 1'b0;
      ls_settle_d <= 1'b0;
      por <= 1'b0;
    end else begin
      hs_settle_d <= hs_settle;
      ls_settle_d <= ls_settle;
      por <= (hs_evt && hs_cfg.reset_enable) || (ls_evt && ls_cfg.reset_enable); // [R2]
    end
  end
  assign O_POR_REQ = por;

  always_comb begin
    set_bits = '0;
    set_bits[S_HS_EVT] = hs_evt; // [R2]
    set_bits[S_LS_EVT] = ls_evt; // [R2]
    set_bits[S_HS_DLY] = hs_settle_d && !hs_settle;
    set_bits[S_LS_DLY] = ls_settle_d && !ls_settle;
    set_bits[S_WAKE] = wake_done;
  end
  assign clr_bits = (wr_pend && (dp_addr == ADDR_STATUS)) ? I_HWDATA[IRQ_W-1:0] : '0;

  // A new event in the clearing cycle stays set
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_bits) | set_bits; // [R17]
    end
  end
  assign O_IRQ = |(status & irq_mask);
  // Pins stay floating as long as software leaves a supervisor event flag standing
  assign O_GPIO_HIZ = status[S_HS_EVT] || status[S_LS_EVT]; // [R3]

  // Power mode sequencing
  assign ls_normal = (ls_cfg.enable && !ls_cfg.full_perf) || (ctrl[C_LMON_EN] && !ctrl[C_LMON_FP]);

  always_comb begin
    next_hold_cnt = hold_cnt;
    if (state == ST_SLEEP && wake && lp_mode >= MODE_HOLD_MIN) begin
      // Low side and monitor each off or in full performance give only the short hold
      next_hold_cnt = ls_normal ? CNT_W'(NORMAL_MASK_CYC - 1) : CNT_W'(FP_MASK_CYC - 1); // [R9] [R10]
    end else if (hold_cnt != '0) begin
      next_hold_cnt = hold_cnt - 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      state <= ST_ACTIVE;
      lp_mode <= MODE_ACTIVE;
      hold_cnt <= '0;
      wake_done <= 1'b0;
    end else begin
      hold_cnt <= next_hold_cnt;
      wake_done <= 1'b0;
      unique case (state)
        ST_ACTIVE: begin
          // Out-of-range mode codes are dropped so the sequencer never parks in an undefined mode
          if (wr_pend && dp_addr == ADDR_MODE && I_HWDATA[2:0] != MODE_ACTIVE && I_HWDATA[2:0] <= MODE_MAX) begin
            lp_mode <= I_HWDATA[2:0];
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            if (lp_mode >= MODE_HOLD_MIN) begin
              state <= ST_WAKE_HOLD;
            end else begin
              state <= ST_ACTIVE;
              lp_mode <= MODE_ACTIVE;
              wake_done <= 1'b1;
            end
          end
        end
        ST_WAKE_HOLD: begin
          if (hold_cnt == '0) begin
            state <= ST_ACTIVE;
            lp_mode <= MODE_ACTIVE;
            wake_done <= 1'b1;
          end
        end
      endcase
    end
  end

  // Oscillator overshoot window after a mode 3 or 4 exit
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      over_cnt <= '0;
    end else if (state == ST_SLEEP && wake && lp_mode >= MODE_HOLD_MIN) begin
      over_cnt <= CNT_W'(OVERSHOOT_CYC); // [R11]
    end else if (over_cnt != '0) begin
      over_cnt <= over_cnt - 1'b1;
    end
  end
  assign O_OSC_OVERSHOOT = over_cnt != '0;

  assign O_CPU_HOLD = state != ST_ACTIVE;
  assign O_MAIN_CLK_MASK = state == ST_WAKE_HOLD;
  assign O_LP_MODE = lp_mode;
  assign O_MAIN_CLK_DIV = ctrl[C_DIV_LO +: 3];
  // No wake mask on the subsystem clock: the overshoot passes straight through
  assign O_SUB_CLK_REQ = ctrl[C_SUB_REQ] || (state != ST_SLEEP); // [R13]

  // Checking helpers
  logic [CNT_W-1:0] hold_age;
  logic hold_long;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      hold_age <= '0;
      hold_long <= 1'b0;
    end else begin
      hold_age <= (state == ST_WAKE_HOLD) ? hold_age + 1'b1 : '0;
      // Latched at the wake edge because software may retune the low side during the hold
      if (state == ST_SLEEP && wake) begin
        hold_long <= ls_normal;
      end
    end
  end

  chk_por_follows_evt: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R2]
    (ls_evt && ls_cfg.reset_enable) |=> O_POR_REQ && status[S_LS_EVT])
    else $error("low side event without reset request");
  chk_no_por_disabled: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R2]
    !((hs_evt && hs_cfg.reset_enable) || (ls_evt && ls_cfg.reset_enable)) |=> !O_POR_REQ)
    else $error("reset request without event");
  chk_gpio_hiz_flags: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R3]
    hs_evt |=> O_GPIO_HIZ)
    else $error("pins not floated after event");
  chk_cmp_off_deep: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R4]
    (deep && !hs_cfg.lowpower_keep) |-> !hs_on)
    else $error("comparator left on in deep sleep");
  chk_long_wake_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R9]
    ($fell(O_MAIN_CLK_MASK) && hold_long) |-> $past(hold_age) == CNT_W'(NORMAL_MASK_CYC - 1))
    else $error("long wake hold length wrong");
  chk_short_wake_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R10]
    ($fell(O_MAIN_CLK_MASK) && !hold_long) |-> $past(hold_age) == CNT_W'(FP_MASK_CYC - 1))
    else $error("short wake hold length wrong");
  chk_overshoot_len: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R11]
    (state == ST_SLEEP && wake && lp_mode >= MODE_HOLD_MIN) |=> O_OSC_OVERSHOOT ##150 !O_OSC_OVERSHOOT)
    else $error("overshoot window length wrong");
  chk_sub_clk_open: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R13]
    O_MAIN_CLK_MASK |-> O_SUB_CLK_REQ)
    else $error("subsystem clock masked on wake");
  chk_flag_sticky: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R17]
    (status[S_HS_EVT] && !clr_bits[S_HS_EVT]) |=> status[S_HS_EVT])
    else $error("event flag dropped without clear");
  chk_reset_no_mask: assert property (@(posedge I_SYS_CLK) // [R5]
    $fell(I_SRST) |-> !hs_settle && !ls_settle && hs_on && ls_on)
    else $error("settling mask started by reset");
  chk_ls_cmp_off: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R4]
    (deep && !ls_cfg.lowpower_keep) |-> !ls_on)
    else $error("low side comparator left on in deep sleep");
  chk_hiz_ls_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R3]
    ls_evt |=> O_GPIO_HIZ)
    else $error("pins not floated after low side event");
  chk_wake_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R9]
    $fell(O_CPU_HOLD) |=> status[S_WAKE])
    else $error("wake done flag not set");
  chk_hold_start: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R9]
    (state == ST_SLEEP && wake && lp_mode >= MODE_HOLD_MIN) |=> O_MAIN_CLK_MASK && O_CPU_HOLD)
    else $error("wake hold not started");
  chk_shallow_wake: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R9]
    (state == ST_SLEEP && wake && lp_mode < MODE_HOLD_MIN) |=> !O_CPU_HOLD && !O_MAIN_CLK_MASK)
    else $error("shallow wake held the cpu");
  chk_settle_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST) // [R16]
    $fell(hs_settle) |=> status[S_HS_DLY])
    else $error("settle done flag not set");
endmodule
`default_nettype wire

// ===== supply_pkg.sv
// Summary of operation
// R1 - A supervisor that comes back on in full-performance mode has its events blocked for a fixed 2 us settling mask.
// R2 - Every supervisor event, false or not, sets its event flag and, with reset enable set, requests a power-on reset.
// R3 - While any supervisor event flag is set, all general-purpose pins are held in high impedance.
// R4 - With the low-power-keep bit at 0 the comparator is switched off in deep sleep modes 2 to 4 and back on in active mode.
// R5 - After a soft power-up clear or power-on reset the supervisors come up enabled without starting the settling mask.
// R6 - Software using full-performance mode should also set the low-power-keep bit of that supervisor.
// R7 - Software should switch a supervisor on in normal mode and select full performance only after the delay has expired.
// R8 - Software should keep both supervisors enabled at all times.
// R9 - With the low-side supervisor or monitor in normal mode, the CPU is held for 150 us on wake from modes 3 and 4.
// R10 - With low-side supervisor and monitor both off or both full-performance, the wake hold lasts only 2 us.
// R11 - On exit from modes 3 and 4 the internal oscillator runs above its programmed rate for up to 6 us.
// R12 - Software should set the main-clock divider to divide by two before modes 3 and 4 and restore it after a wait.
// R13 - The subsystem clock is not masked on exit from modes 3 and 4, so the overshoot reaches its peripherals.
// R14 - Software keeping the subsystem clock request set should halt dependent modules across modes 3 and 4.
// R15 - Software should wait until both settling-delay flags read 0 before entering modes 2 to 4.
// R16 - A supervisor re-enabled in normal mode gets a settling delay of about 150 us.
// R17 - Supervisor event flags stay set until software clears them or a reset clears them.
package supply_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FP_MASK_NS = 2000;
  localparam int NORMAL_MASK_NS = 150000;
  localparam int OVERSHOOT_NS = 6000;
  // Least times round up, the overshoot is a longest time and rounds down
  localparam int FP_MASK_CYC = (FP_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORMAL_MASK_CYC = (NORMAL_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVERSHOOT_CYC = OVERSHOOT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;

  localparam int CTRL_W = 15;
  localparam int C_HS = 0;
  localparam int C_LS = 4;
  localparam int C_EN = 0;
  localparam int C_FP = 1;
  localparam int C_RST = 2;
  localparam int C_KEEP = 3;
  localparam int C_LMON_EN = 8;
  localparam int C_LMON_FP = 9;
  localparam int C_SUB_REQ = 10;
  localparam int C_DIV_LO = 11;
  localparam int C_MAIN_OSC = 14;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0155;

  localparam int IRQ_W = 5;
  localparam int S_HS_EVT = 0;
  localparam int S_LS_EVT = 1;
  localparam int S_HS_DLY = 2;
  localparam int S_LS_DLY = 3;
  localparam int S_WAKE = 4;

  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_DEEP_MIN = 3'h2;
  localparam logic [2:0] MODE_HOLD_MIN = 3'h3;
  localparam logic [2:0] MODE_MAX = 3'h4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic enable;
    logic full_perf;
    logic reset_enable;
    logic lowpower_keep;
  } sup_cfg_t;

  typedef struct packed {
    logic hs_cmp_on;
    logic ls_cmp_on;
    logic hs_settling;
    logic ls_settling;
  } sup_state_t;
endpackage

// ===== supervisor_channel.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_channel
  import supply_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire supply_pkg::sup_cfg_t i_cfg,
  input wire logic i_deep,
  input wire logic i_trip,
  output logic o_cmp_on,
  output logic o_event,
  output logic o_settling
);
  logic prev_on;
  logic [CNT_W-1:0] mask_cnt;
  logic rise;
  logic [CNT_W-1:0] age;
  logic [CNT_W-1:0] mask_len;

  assign o_cmp_on = i_cfg.enable && !(i_deep && !i_cfg.lowpower_keep); // [R4]
  assign rise = o_cmp_on && !prev_on;
  assign o_settling = rise || (mask_cnt != '0);
  // A trip during the mask is dropped; after it every trip counts, settled or not
  assign o_event = o_cmp_on && i_trip && !o_settling; // [R1] [R2]

  // Starts at one so a comparator enabled out of reset starts no mask
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev_on <= 1'b1; // [R5]
    end else begin
      prev_on <= o_cmp_on;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mask_cnt <= '0;
    end else if (rise) begin
      mask_cnt <= i_cfg.full_perf ? CNT_W'(FP_MASK_CYC - 1) : CNT_W'(NORMAL_MASK_CYC - 1); // [R1] [R16]
    end else if (mask_cnt != '0) begin
      mask_cnt <= mask_cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      age <= '0;
      mask_len <= '0;
    end else begin
      age <= rise ? CNT_W'(1) : (o_settling ? age + 1'b1 : '0);
      if (rise) begin
        mask_len <= i_cfg.full_perf ? CNT_W'(FP_MASK_CYC) : CNT_W'(NORMAL_MASK_CYC);
      end
    end
  end

  chk_mask_length: assert property (@(posedge i_clk) disable iff (i_srst) // [R1]
    $fell(o_settling) |-> age == mask_len)
    else $error("settling mask length wrong");
  chk_normal_mask_len: assert property (@(posedge i_clk) disable iff (i_srst) // [R16]
    (rise && !i_cfg.full_perf) |-> ##1 mask_cnt == CNT_W'(NORMAL_MASK_CYC - 1))
    else $error("normal mode settling delay not loaded");
  chk_event_masked: assert property (@(posedge i_clk) disable iff (i_srst) // [R1]
    (rise || (age != '0 && age < mask_len)) |-> !o_event)
    else $error("event passed during settling mask");
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import supply_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hs_trip = 1'b0;
  logic ls_trip = 1'b0;
  logic wake = 1'b0;
  logic [31:0] hrdata;
  logic hready, hresp, irq, por_req, gpio_hiz, cpu_hold, main_mask, sub_req, overshoot, mon_on;
  logic [2:0] main_div, lp_mode;
  sup_state_t sup_state;
  int fails = 0;
  int samples_checked = 0;
  int por_cnt = 0;
  logic [15:0] lfsr = 16'hAE75;

  supply_supervisor_event_mask u_supply_supervisor_event_mask (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_HS_TRIP(hs_trip), .I_LS_TRIP(ls_trip), .I_WAKE(wake),
    .O_IRQ(irq), .O_POR_REQ(por_req), .O_GPIO_HIZ(gpio_hiz), .O_CPU_HOLD(cpu_hold),
    .O_MAIN_CLK_MASK(main_mask), .O_SUB_CLK_REQ(sub_req), .O_OSC_OVERSHOOT(overshoot),
    .O_LS_MON_ON(mon_on), .O_MAIN_CLK_DIV(main_div), .O_LP_MODE(lp_mode), .O_SUP_STATE(sup_state)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // Requests last only while the trip is seen, so they are counted here rather than polled
  always @(posedge clk) begin
    if (por_req === 1'b1) begin
      por_cnt <= por_cnt + 1;
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    finish_test();
  end

  task automatic test_end(input string nm);
    $display("TEST %s finished, mismatches so far %0d", nm, fails);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    `CHECK("hresp", HRESP_OKAY, hresp)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    @(posedge clk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHECK(nm, e, q)
  endtask

  function automatic logic sel_sig(input int k);
    case (k)
      0: return main_mask;
      1: return overshoot;
      2: return sup_state.hs_settling | sup_state.ls_settling;
      default: return lp_mode === MODE_ACTIVE;
    endcase
  endfunction

  // Counts edges until the selected signal is sampled at level v
  task automatic wait_sig(input int k, input logic v, output int n);
    n = 0;
    while (sel_sig(k) !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (sel_sig(k) !== v) begin
      fails++;
      finish_test();
    end
  endtask

  function automatic int exp_hold(input logic [14:0] c, input int m);
    if (m < 3) return 0;
    return ((c[C_LS+C_EN] & ~c[C_LS+C_FP]) | (c[C_LMON_EN] & ~c[C_LMON_FP])) ? NORMAL_MASK_CYC : FP_MASK_CYC;
  endfunction

  function automatic logic exp_cmp_on(input logic [14:0] c, input int base, input int m);
    return c[base+C_EN] & ~((m >= 2) & ~c[base+C_KEEP]);
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
  endfunction

  initial begin
    logic [31:0] q;
    logic [14:0] c;
    int n;
    int k;
    int m;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd_chk("ctrl", ADDR_CTRL, {17'h0, CTRL_RESET});
    rd_chk("status", ADDR_STATUS, 32'h0);
    rd_chk("mask", ADDR_MASK, 32'h0);
    rd_chk("state", ADDR_STATE, 32'h0000000C);
    rd_chk("unmapped", 8'h40, 32'h0);
    test_end("reset");
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_CTRL, (s == 1) ? 32'h00000115 : 32'h00000155);
      n = por_cnt;
      hs_trip <= (s == 0);
      ls_trip <= (s != 0);
      cyc(6);
      hs_trip <= 1'b0;
      ls_trip <= 1'b0;
      cyc(4);
      `CHECK("por", s != 1, por_cnt != n)
      `CHECK("hiz", 1'b1, gpio_hiz)
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      `CHECK("flag", 1'b1, q[s > 0])
      `CHECK("irq_off", 1'b0, irq)
      wr(ADDR_MASK, 32'h1 << (s > 0));
      `CHECK("irq_on", 1'b1, irq)
      wr(ADDR_STATUS, 32'h1 << (s > 0));
      `CHECK("hiz_clr", 1'b0, gpio_hiz)
      `CHECK("irq_clr", 1'b0, irq)
      wr(ADDR_MASK, 32'h0);
    end
    test_end("events");
    // Trip is held high across the re-enable: only the mask keeps the flag clear
    for (int f = 1; f >= 0; f--) begin
      wr(ADDR_CTRL, 32'h00000154);
      hs_trip <= 1'b1;
      cyc(4);
      wr(ADDR_CTRL, (f == 1) ? 32'h00000157 : 32'h00000155);
      wait_sig(2, 1'b1, n);
      wait_sig(2, 1'b0, n);
      `CHECK("settle_len", (f == 1) ? FP_MASK_CYC : NORMAL_MASK_CYC, n)
      `CHECK("masked", 1'b0, gpio_hiz)
      cyc(4);
      `CHECK("late_event", 1'b1, gpio_hiz)
      hs_trip <= 1'b0;
      cyc(4);
      wr(ADDR_STATUS, 32'h0000001F);
    end
    test_end("settling");
    for (int i = 0; i < 5; i++) begin
      m = (i < 4) ? i + 1 : 3;
      c = (i < 4) ? 15'h0FFD : 15'h0155;
      wr(ADDR_CTRL, {17'h0, c});
      wait_sig(2, 1'b0, n);
      wr(ADDR_MODE, m);
      cyc(2);
      `CHECK("sub_sleep", c[C_SUB_REQ], sub_req)
      `CHECK("mon_on", c[C_LMON_EN] & ~((m >= 2) & ~c[C_LS+C_KEEP]), mon_on)
      `CHECK("div", c[C_DIV_LO +: 3], main_div)
      `CHECK("mode", 3'(m), lp_mode)
      `CHECK("hs_cmp", exp_cmp_on(c, C_HS, m), sup_state.hs_cmp_on)
      `CHECK("ls_cmp", exp_cmp_on(c, C_LS, m), sup_state.ls_cmp_on)
      `CHECK("cpu_hold", 1'b1, cpu_hold)
      wake <= 1'b1;
      if (m >= 3) begin
        wait_sig(0, 1'b1, n);
        `CHECK("sub_req", 1'b1, sub_req)
        `CHECK("overshoot", 1'b1, overshoot)
        wait_sig(0, 1'b0, n);
        `CHECK("wake_mask", exp_hold(c, m), n)
        if (exp_hold(c, m) < OVERSHOOT_CYC) begin
          wait_sig(1, 1'b0, k);
          `CHECK("overshoot_len", OVERSHOOT_CYC, n + k)
        end
      end
      wait_sig(3, 1'b1, n);
      wake <= 1'b0;
      cyc(4);
      `CHECK("cpu_run", 1'b0, cpu_hold)
      `CHECK("hs_back_on", 1'b1, sup_state.hs_cmp_on)
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      `CHECK("wake_done", 1'b1, q[S_WAKE])
      wr(ADDR_STATUS, 32'h00000013);
    end
    test_end("wake");
    wait_sig(2, 1'b0, n);
    cyc(4);
    rd_chk("settle_done", ADDR_STATUS, 32'h0000000C);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(ADDR_MASK, {16'h0, lfsr});
      rd_chk("mask_rb", ADDR_MASK, {27'h0, lfsr[4:0]});
      `CHECK("irq", |(5'h0C & lfsr[4:0]), irq)
      wr(ADDR_STATE, {16'h0, lfsr});
      wr(ADDR_MODE, {29'h0, 3'h5 | {1'b0, lfsr[1:0]}});
      `CHECK("mode_ignored", MODE_ACTIVE, lp_mode)
      rd_chk("unmapped_rnd", {2'b01, lfsr[5:2], 2'b00}, 32'h0);
    end
    wr(ADDR_MASK, 32'h0);
    test_end("random");
    finish_test();
  end
endmodule
`default_nettype wire
